// *** dv/ccprd_far_port.sv ***
// behavioural model of the remote port across the cable
module ccprd_far_port (
	input wire logic clk,
	input wire ccprd_pkg::ccprd_drive_t drive,
	input wire logic [2:0] role,
	input wire logic flip,
	input wire logic cable,
	input wire logic slow,
	output ccprd_pkg::ccprd_sense_t sense
);
	timeunit 1ns;
	timeprecision 1ps;
	// role: 0 open, 1 sink, 2 source, 3 debug, 4 audio, 5 dual that mirrors the device
	logic up;
	logic dn;
	logic srcNow;
	logic [15:0] vbusLag;
	ccprd_pkg::ccprd_cc_t lnk;
	ccprd_pkg::ccprd_cc_t oth;
	assign up = drive.pullUp1 | drive.pullUp2;
	assign dn = drive.pullDown1 | drive.pullDown2;
	// a dual partner takes the opposite power role, so a power swap is followed
	assign srcNow = (role == 3'h2) || (role == 3'h5 && dn);
	// slow mode delays vbus so cc settles well before power shows
	always_ff @(posedge clk) begin
		vbusLag <= {vbusLag[14:0], srcNow};
	end
	always_comb begin
		lnk = ccprd_pkg::CCPRD_CC_OPEN;
		oth = ccprd_pkg::CCPRD_CC_OPEN;
		if (up && (role == 3'h1 || role == 3'h3 || role == 3'h5)) lnk = ccprd_pkg::CCPRD_CC_RD;
		if (up && role == 3'h4) lnk = ccprd_pkg::CCPRD_CC_RA;
		if (dn && srcNow) lnk = ccprd_pkg::CCPRD_CC_RP;
		if (up && (cable || role == 3'h4)) oth = ccprd_pkg::CCPRD_CC_RA;
		if (up && role == 3'h3) oth = ccprd_pkg::CCPRD_CC_RD;
		sense.cc1 = flip ? oth : lnk;
		sense.cc2 = flip ? lnk : oth;
		sense.vbusPresent = slow ? vbusLag[15] : srcNow;
	end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the cc port role detection core
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, trySrcEn, trySnkEn, prSwap, drSwap, vconnSwap;
	logic [1:0] portMode, currentCap;
	logic [2:0] role;
	logic flip, cable, slow, attached, audioAcc, debugAcc;
	ccprd_pkg::ccprd_sense_t sense;
	ccprd_pkg::ccprd_drive_t drive;
	ccprd_pkg::ccprd_state_t state;
	int errorCnt, samplesChecked;
	// short counts keep the run small; expectations follow these values
	ccprd_core #(.DEBOUNCE_CYC(4), .DRP_PERIOD_CYC(40), .DRP_SRC_PCT(50), .DRP_TRANS_CYC(2),
		.TRY_CYC(20)) ccprd_core_inst (.clk(clk), .reset(reset), .portMode(portMode),
		.trySrcEn(trySrcEn), .trySnkEn(trySnkEn), .currentCap(currentCap), .sense(sense),
		.prSwap(prSwap), .drSwap(drSwap), .vconnSwap(vconnSwap), .drive(drive),
		.state(state), .attached(attached), .audioAcc(audioAcc), .debugAcc(debugAcc));
	ccprd_far_port ccprd_far_port_inst (.clk(clk), .drive(drive), .role(role), .flip(flip),
		.cable(cable), .slow(slow), .sense(sense));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wrapUp;
		$display("errors=%0d checks=%0d", errorCnt, samplesChecked);
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic waitState(input ccprd_pkg::ccprd_state_t s);
		int n;
		n = 0;
		while (state !== s && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n == 400) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, state, s);
			wrapUp();
		end
		repeat (2) @(negedge clk);
	endtask
	task automatic restart(input logic [1:0] m, input logic [2:0] r, input logic [2:0] fcs,
		input logic [1:0] tries);
		@(posedge clk);
		portMode <= m;
		role <= r;
		{flip, cable, slow} <= fcs;
		{trySrcEn, trySnkEn} <= tries;
		currentCap <= 2'h1;
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic setRole(input logic [2:0] r);
		@(posedge clk);
		role <= r;
	endtask
	// which is {prSwap, drSwap, vconnSwap}
	task automatic swapPulse(input logic [2:0] which);
		@(posedge clk);
		{prSwap, drSwap, vconnSwap} <= which;
		@(posedge clk);
		{prSwap, drSwap, vconnSwap} <= 3'h0;
		repeat (3) @(negedge clk);
	endtask
	task automatic tSource(input logic f, input logic c);
		restart(2'h0, 3'h0, {f, c, 1'b0}, 2'h0);
		chk(drive.vbusOn, 1'b0);
		chk({drive.pullUp1, drive.pullUp2, drive.pullUpSel}, 4'hD);
		swapPulse(3'h2);
		chk(drive.dataDfp, 1'b0);
		setRole(3'h1);
		waitState(ccprd_pkg::CCPRD_ST_SRC_ATT);
		chk({drive.vbusOn, drive.flipRoute, drive.dataDfp}, {1'b1, f, 1'b1});
		chk({drive.vconnOn1, drive.vconnOn2}, c ? (f ? 2'h2 : 2'h1) : 2'h0);
		@(posedge clk);
		currentCap <= 2'h3;
		repeat (2) @(negedge clk);
		chk(drive.pullUpSel, 2'h3);
		setRole(3'h0);
		waitState(ccprd_pkg::CCPRD_ST_SRC_UNATT);
		chk({drive.vbusOn, drive.vconnOn1, drive.vconnOn2, attached}, 4'h0);
	endtask
	task automatic tSink;
		restart(2'h1, 3'h2, 3'h5, 2'h0);
		chk({drive.pullDown1, drive.pullDown2, drive.pullUp1, drive.pullUp2}, 4'hC);
		// rp is already settled here while vbus is still held back
		repeat (10) @(negedge clk);
		chk(attached, 1'b0);
		waitState(ccprd_pkg::CCPRD_ST_SNK_ATT);
		chk({drive.flipRoute, drive.loadLimit, drive.dataDfp, drive.vbusOn}, 5'h1C);
		setRole(3'h0);
		waitState(ccprd_pkg::CCPRD_ST_SNK_UNATT);
		chk(attached, 1'b0);
	endtask
	task automatic tAcc;
		restart(2'h0, 3'h3, 3'h0, 2'h0);
		waitState(ccprd_pkg::CCPRD_ST_DEBUG);
		chk({debugAcc, audioAcc}, 2'h2);
		setRole(3'h0);
		waitState(ccprd_pkg::CCPRD_ST_SRC_UNATT);
		setRole(3'h4);
		waitState(ccprd_pkg::CCPRD_ST_AUDIO);
		chk({debugAcc, audioAcc}, 2'h1);
	endtask
	task automatic tDrp;
		int srcSeen, snkSeen, vbusSeen;
		restart(2'h2, 3'h0, 3'h0, 2'h0);
		srcSeen = 0;
		snkSeen = 0;
		vbusSeen = 0;
		repeat (120) begin
			@(negedge clk);
			if (drive.pullUp1 === 1'b1) srcSeen++;
			if (drive.pullDown1 === 1'b1) snkSeen++;
			if (drive.vbusOn !== 1'b0) vbusSeen++;
		end
		chk({srcSeen > 40, snkSeen > 40, vbusSeen == 0}, 3'h7);
		setRole(3'h1);
		waitState(ccprd_pkg::CCPRD_ST_SRC_ATT);
		repeat (60) @(negedge clk);
		chk({state, drive.vbusOn}, {ccprd_pkg::CCPRD_ST_SRC_ATT, 1'b1});
		setRole(3'h0);
		waitState(ccprd_pkg::CCPRD_ST_SRC_UNATT);
		setRole(3'h2);
		waitState(ccprd_pkg::CCPRD_ST_SNK_ATT);
		repeat (60) @(negedge clk);
		chk({state, drive.pullDown1}, {ccprd_pkg::CCPRD_ST_SNK_ATT, 1'b1});
	endtask
	task automatic tTry;
		restart(2'h2, 3'h0, 3'h0, 2'h2);
		// meet the dual partner in the transition gap, just before the sink phase begins
		repeat (20) @(negedge clk);
		setRole(3'h5);
		waitState(ccprd_pkg::CCPRD_ST_SRC_ATT);
		restart(2'h2, 3'h5, 3'h0, 2'h1);
		waitState(ccprd_pkg::CCPRD_ST_SNK_ATT);
	endtask
	task automatic tSwap;
		restart(2'h0, 3'h5, 3'h2, 2'h0);
		waitState(ccprd_pkg::CCPRD_ST_SRC_ATT);
		swapPulse(3'h2);
		chk({drive.dataDfp, drive.vbusOn, drive.pullUp1, drive.vconnOn2}, 4'h7);
		swapPulse(3'h1);
		chk({drive.dataDfp, drive.vbusOn, drive.pullUp1, drive.vconnOn2}, 4'h6);
		swapPulse(3'h4);
		repeat (20) @(negedge clk);
		chk({drive.dataDfp, drive.vbusOn, drive.pullUp1, drive.vconnOn2, drive.pullDown1,
			attached}, 6'h03);
	endtask
	initial begin
		reset = 1'b1;
		portMode = 2'h0;
		{trySrcEn, trySnkEn, prSwap, drSwap, vconnSwap} = 5'h00;
		currentCap = 2'h1;
		{role, flip, cable, slow} = 6'h00;
		errorCnt = 0;
		samplesChecked = 0;
		tSource(1'b0, 1'b1);
		tSource(1'b1, 1'b0);
		tSink();
		tAcc();
		tDrp();
		tTry();
		tSwap();
		wrapUp();
	end
endmodule

// *** logic/ccprd_core.sv ***
// attach, orientation, drp toggling and role swap logic of the cc port
`include "ccprd_defs.svh"
module ccprd_core #(
	parameter int DEBOUNCE_CYC = `CCPRD_DEBOUNCE_CYC,
	parameter int DRP_PERIOD_CYC = `CCPRD_DRP_PERIOD_CYC,
	parameter int DRP_SRC_PCT = `CCPRD_DRP_SRC_PCT,
	parameter int DRP_TRANS_CYC = `CCPRD_DRP_TRANS_CYC,
	parameter int TRY_CYC = `CCPRD_TRY_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] portMode,
	input wire logic trySrcEn,
	input wire logic trySnkEn,
	input wire logic [1:0] currentCap,
	input wire ccprd_pkg::ccprd_sense_t sense,
	input wire logic prSwap,
	input wire logic drSwap,
	input wire logic vconnSwap,
	output ccprd_pkg::ccprd_drive_t drive,
	output ccprd_pkg::ccprd_state_t state,
	output logic attached,
	output logic audioAcc,
	output logic debugAcc
);
	localparam int SRC_CYC = DRP_PERIOD_CYC * DRP_SRC_PCT / 100;
	localparam int TW = $clog2(DRP_PERIOD_CYC + TRY_CYC + DRP_TRANS_CYC + 2);

	ccprd_pkg::ccprd_sense_t deb;
	logic debChanged;
	ccprd_pkg::ccprd_state_t next_state;
	logic [TW-1:0] timer;
	logic tryUsed;
	logic afterTrans;
	logic powerSrc;
	logic dataDfp;
	logic vconnSrc;
	logic flip;
	logic isSrcState;
	logic rd1;
	logic rd2;
	logic ra1;
	logic ra2;
	logic sinkSeen;
	logic srcSeen;
	logic isDrp;

	// raw cc comparator levels bounce on insertion and hide pd traffic
	ccprd_debounce #(.WIDTH(5), .COUNT(DEBOUNCE_CYC)) u_deb (
		.clk(clk),
		.reset(reset),
		.raw(sense),
		.stable(deb),
		.changed(debChanged)
	);

	assign rd1 = deb.cc1 == ccprd_pkg::CCPRD_CC_RD;
	assign rd2 = deb.cc2 == ccprd_pkg::CCPRD_CC_RD;
	assign ra1 = deb.cc1 == ccprd_pkg::CCPRD_CC_RA;
	assign ra2 = deb.cc2 == ccprd_pkg::CCPRD_CC_RA;
	assign sinkSeen = rd1 ^ rd2;
	assign srcSeen = deb.vbusPresent;
	assign isDrp = portMode == `CCPRD_MODE_DRP;
	assign isSrcState = state == ccprd_pkg::CCPRD_ST_SRC_UNATT
		|| state == ccprd_pkg::CCPRD_ST_SRC_ATT || state == ccprd_pkg::CCPRD_ST_TRY_SRC
		|| state == ccprd_pkg::CCPRD_ST_AUDIO || state == ccprd_pkg::CCPRD_ST_DEBUG;

	always_comb begin
		next_state = state;
		case (state)
			ccprd_pkg::CCPRD_ST_IDLE: begin
				if (portMode == `CCPRD_MODE_SNK) begin
					next_state = ccprd_pkg::CCPRD_ST_SNK_UNATT;
				end else begin
					next_state = ccprd_pkg::CCPRD_ST_SRC_UNATT;
				end
			end
			ccprd_pkg::CCPRD_ST_SRC_UNATT: begin
				if (rd1 && rd2) begin
					next_state = ccprd_pkg::CCPRD_ST_DEBUG;
				end else if (ra1 && ra2) begin
					next_state = ccprd_pkg::CCPRD_ST_AUDIO;
				end else if (sinkSeen) begin
					if (isDrp && trySnkEn && !tryUsed) begin
						next_state = ccprd_pkg::CCPRD_ST_TRY_SNK;
					end else begin
						next_state = ccprd_pkg::CCPRD_ST_SRC_ATT;
					end
				end else if (isDrp && timer >= TW'(SRC_CYC)) begin
					next_state = ccprd_pkg::CCPRD_ST_TRANS;
				end
			end
			ccprd_pkg::CCPRD_ST_SNK_UNATT: begin
				if (srcSeen) begin
					if (isDrp && trySrcEn && !tryUsed) begin
						next_state = ccprd_pkg::CCPRD_ST_TRY_SRC;
					end else begin
						next_state = ccprd_pkg::CCPRD_ST_SNK_ATT;
					end
				end else if (isDrp && timer >= TW'(DRP_PERIOD_CYC - SRC_CYC)) begin
					next_state = ccprd_pkg::CCPRD_ST_TRANS;
				end
			end
			ccprd_pkg::CCPRD_ST_TRANS: begin
				if (timer >= TW'(DRP_TRANS_CYC)) begin
					next_state = afterTrans ? ccprd_pkg::CCPRD_ST_SRC_UNATT
						: ccprd_pkg::CCPRD_ST_SNK_UNATT;
				end
			end
			ccprd_pkg::CCPRD_ST_TRY_SRC: begin
				if (sinkSeen) begin
					next_state = ccprd_pkg::CCPRD_ST_SRC_ATT;
				end else if (timer >= TW'(TRY_CYC)) begin
					next_state = ccprd_pkg::CCPRD_ST_SNK_UNATT;
				end
			end
			ccprd_pkg::CCPRD_ST_TRY_SNK: begin
				if (srcSeen) begin
					next_state = ccprd_pkg::CCPRD_ST_SNK_ATT;
				end else if (timer >= TW'(TRY_CYC)) begin
					next_state = ccprd_pkg::CCPRD_ST_SRC_UNATT;
				end
			end
			ccprd_pkg::CCPRD_ST_SRC_ATT: begin
				// power swap keeps the link; only the source duty moves away
				if (powerSrc && !(flip ? rd2 : rd1)) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end else if (!powerSrc && !srcSeen && debChanged) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end
			end
			ccprd_pkg::CCPRD_ST_SNK_ATT: begin
				if (!powerSrc && !srcSeen) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end else if (powerSrc && !(flip ? rd2 : rd1) && debChanged) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end
			end
			ccprd_pkg::CCPRD_ST_AUDIO: begin
				if (!(ra1 && ra2)) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end
			end
			ccprd_pkg::CCPRD_ST_DEBUG: begin
				if (!(rd1 && rd2)) begin
					next_state = ccprd_pkg::CCPRD_ST_IDLE;
				end
			end
			default: begin
				next_state = ccprd_pkg::CCPRD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ccprd_pkg::CCPRD_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// one timer shared by toggle phases, transition gap and try window
	always_ff @(posedge clk) begin
		if (reset || next_state != state) begin
			timer <= '0;
		end else if (timer != '1) begin
			timer <= timer + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			afterTrans <= 1'b0;
		end else if (next_state == ccprd_pkg::CCPRD_ST_TRANS && state != next_state) begin
			afterTrans <= state == ccprd_pkg::CCPRD_ST_SNK_UNATT;
		end
	end

	// try window only once per connection, cleared when the port restarts
	always_ff @(posedge clk) begin
		if (reset || state == ccprd_pkg::CCPRD_ST_IDLE) begin
			tryUsed <= 1'b0;
		end else if (state == ccprd_pkg::CCPRD_ST_TRY_SRC
			|| state == ccprd_pkg::CCPRD_ST_TRY_SNK) begin
			tryUsed <= 1'b1;
		end
	end

	// roles fixed on attach; swaps only honoured while attached
	always_ff @(posedge clk) begin
		if (reset) begin
			powerSrc <= 1'b0;
			dataDfp <= 1'b0;
			vconnSrc <= 1'b0;
			flip <= 1'b0;
		end else if (state != ccprd_pkg::CCPRD_ST_SRC_ATT
			&& next_state == ccprd_pkg::CCPRD_ST_SRC_ATT) begin
			powerSrc <= 1'b1;
			dataDfp <= 1'b1;
			flip <= rd2;
			vconnSrc <= rd2 ? ra1 : ra2;
		end else if (state != ccprd_pkg::CCPRD_ST_SNK_ATT
			&& next_state == ccprd_pkg::CCPRD_ST_SNK_ATT) begin
			powerSrc <= 1'b0;
			dataDfp <= 1'b0;
			vconnSrc <= 1'b0;
			flip <= deb.cc2 == ccprd_pkg::CCPRD_CC_RP;
		end else if (attached) begin
			if (prSwap) begin
				powerSrc <= !powerSrc;
			end
			if (drSwap) begin
				dataDfp <= !dataDfp;
			end
			if (vconnSwap) begin
				vconnSrc <= !vconnSrc;
			end
		end else if (state == ccprd_pkg::CCPRD_ST_IDLE) begin
			powerSrc <= 1'b0;
			dataDfp <= 1'b0;
			vconnSrc <= 1'b0;
		end
	end

	assign attached = state == ccprd_pkg::CCPRD_ST_SRC_ATT
		|| state == ccprd_pkg::CCPRD_ST_SNK_ATT;

	always_ff @(posedge clk) begin
		if (reset) begin
			drive <= '0;
			audioAcc <= 1'b0;
			debugAcc <= 1'b0;
		end else begin
			drive.pullUp1 <= attached ? powerSrc : isSrcState;
			drive.pullUp2 <= attached ? powerSrc : isSrcState;
			drive.pullDown1 <= attached ? !powerSrc
				: state == ccprd_pkg::CCPRD_ST_SNK_UNATT
				|| state == ccprd_pkg::CCPRD_ST_TRY_SNK;
			drive.pullDown2 <= attached ? !powerSrc
				: state == ccprd_pkg::CCPRD_ST_SNK_UNATT
				|| state == ccprd_pkg::CCPRD_ST_TRY_SNK;
			drive.pullUpSel <= currentCap;
			drive.vbusOn <= attached && powerSrc;
			drive.vconnOn1 <= attached && vconnSrc && flip;
			drive.vconnOn2 <= attached && vconnSrc && !flip;
			drive.flipRoute <= flip;
			drive.dataDfp <= attached && dataDfp;
			// sink may never draw more than the advertised level
			if (attached && !powerSrc) begin
				drive.loadLimit <= flip ? 2'(deb.cc2) : 2'(deb.cc1);
			end else begin
				drive.loadLimit <= `CCPRD_CUR_DEF;
			end
			audioAcc <= state == ccprd_pkg::CCPRD_ST_AUDIO;
			debugAcc <= state == ccprd_pkg::CCPRD_ST_DEBUG;
		end
	end

	chk_vbus_off_unatt: assert property (@(posedge clk) disable iff (reset)
		!$past(attached) |-> !drive.vbusOn)
		else $error("vbus on while not attached");
	chk_src_attach_pwr: assert property (@(posedge clk) disable iff (reset)
		(attached && powerSrc) |=> drive.vbusOn)
		else $error("vbus not applied after sink attach");
	chk_detach_off: assert property (@(posedge clk) disable iff (reset)
		(state == ccprd_pkg::CCPRD_ST_IDLE) |=> !drive.vbusOn && !drive.vconnOn1
		&& !drive.vconnOn2)
		else $error("power left on after detach");
	chk_sink_pulldown: assert property (@(posedge clk) disable iff (reset)
		(state == ccprd_pkg::CCPRD_ST_SNK_UNATT) |=> drive.pullDown1 && drive.pullDown2
		&& !drive.pullUp1)
		else $error("sink terminations wrong");
	chk_sink_by_vbus: assert property (@(posedge clk) disable iff (reset)
		(state != ccprd_pkg::CCPRD_ST_SNK_ATT) ##1 (state == ccprd_pkg::CCPRD_ST_SNK_ATT)
		|-> $past(deb.vbusPresent))
		else $error("sink attached without vbus");
	chk_vconn_other: assert property (@(posedge clk) disable iff (reset)
		drive.vconnOn1 |-> !drive.vconnOn2 && drive.flipRoute)
		else $error("vconn on wrong pin");
	chk_try_once: assert property (@(posedge clk) disable iff (reset)
		(state == ccprd_pkg::CCPRD_ST_TRY_SRC || state == ccprd_pkg::CCPRD_ST_TRY_SNK)
		|-> !$past(tryUsed) || $past(state) == state)
		else $error("preference applied twice");
	chk_pr_swap: assert property (@(posedge clk) disable iff (reset)
		(attached && prSwap && !drSwap && !vconnSwap && next_state == state)
		|=> powerSrc != $past(powerSrc) && dataDfp == $past(dataDfp)
		&& vconnSrc == $past(vconnSrc))
		else $error("power swap altered other roles");
	chk_dr_swap: assert property (@(posedge clk) disable iff (reset)
		(attached && drSwap && !prSwap && !vconnSwap && next_state == state)
		|=> dataDfp != $past(dataDfp) && powerSrc == $past(powerSrc))
		else $error("data swap failed");
	chk_vconn_swap: assert property (@(posedge clk) disable iff (reset)
		(attached && vconnSwap && !prSwap && !drSwap && next_state == state)
		|=> vconnSrc != $past(vconnSrc) && dataDfp == $past(dataDfp))
		else $error("vconn swap failed");
	chk_toggle_bound: assert property (@(posedge clk) disable iff (reset)
		(state == ccprd_pkg::CCPRD_ST_TRANS) |-> timer <= TW'(DRP_TRANS_CYC))
		else $error("transition gap too long");
	chk_pullup_sel: assert property (@(posedge clk) disable iff (reset)
		!$past(reset) |-> drive.pullUpSel == $past(currentCap))
		else $error("pull-up selection not following current level");
	chk_src_pullups: assert property (@(posedge clk) disable iff (reset)
		(state == ccprd_pkg::CCPRD_ST_SRC_UNATT) |=> drive.pullUp1 && drive.pullUp2 && !drive.pullDown1)
		else $error("source terminations wrong");
	cov_try_snk: cover property (@(posedge clk) disable iff (reset)
		state == ccprd_pkg::CCPRD_ST_TRY_SNK);

	cov_src_attach: cover property (@(posedge clk) disable iff (reset)
		state == ccprd_pkg::CCPRD_ST_SRC_ATT);
	cov_snk_attach: cover property (@(posedge clk) disable iff (reset)
		state == ccprd_pkg::CCPRD_ST_SNK_ATT);
	cov_try_src: cover property (@(posedge clk) disable iff (reset)
		state == ccprd_pkg::CCPRD_ST_TRY_SRC);
	cov_audio: cover property (@(posedge clk) disable iff (reset)
		state == ccprd_pkg::CCPRD_ST_AUDIO);
endmodule

// *** logic/ccprd_debounce.sv ***
// synchroniser and debounce filter for one sensed level vector
module ccprd_debounce #(
	parameter int WIDTH = 5,
	parameter int COUNT = 10000
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] stable,
	output logic changed
);
	logic [WIDTH-1:0] syncA;
	logic [WIDTH-1:0] syncB;
	logic [$clog2(COUNT+1)-1:0] cnt;

	always_ff @(posedge clk) begin
		if (reset) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= raw;
			syncB <= syncA;
		end
	end

	// the input must differ from the stable level for the whole count before it is accepted
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt <= '0;
			stable <= '0;
			changed <= 1'b0;
		end else begin
			changed <= 1'b0;
			if (syncB == stable) begin
				cnt <= '0;
			end else if (cnt == ($clog2(COUNT+1))'(COUNT - 1)) begin
				cnt <= '0;
				stable <= syncB;
				changed <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule

// *** logic/ccprd_defs.svh ***
// timing counts and encodings for the cc port role detection block
`ifndef CCPRD_DEFS_SVH
`define CCPRD_DEFS_SVH
`define CCPRD_CLK_MHZ 100
`define CCPRD_DEBOUNCE_US 100
`define CCPRD_DEBOUNCE_CYC (`CCPRD_DEBOUNCE_US * `CCPRD_CLK_MHZ)
`define CCPRD_DRP_PERIOD_US 75
`define CCPRD_DRP_PERIOD_CYC (`CCPRD_DRP_PERIOD_US * `CCPRD_CLK_MHZ)
`define CCPRD_DRP_SRC_PCT 50
`define CCPRD_DRP_TRANS_US 1
`define CCPRD_DRP_TRANS_CYC (`CCPRD_DRP_TRANS_US * `CCPRD_CLK_MHZ)
`define CCPRD_TRY_US 100
`define CCPRD_TRY_CYC (`CCPRD_TRY_US * `CCPRD_CLK_MHZ)
`define CCPRD_MODE_SRC 2'h0
`define CCPRD_MODE_SNK 2'h1
`define CCPRD_MODE_DRP 2'h2
`define CCPRD_CUR_DEF 2'h1
`endif

// *** logic/ccprd_pkg.sv ***
// types of the cc port role detection block
package ccprd_pkg;
	// termination seen on one cc pin, already classified by the analog front end
	typedef enum logic [1:0] {
		CCPRD_CC_OPEN = 2'h0,
		CCPRD_CC_RA = 2'h1,
		CCPRD_CC_RD = 2'h2,
		CCPRD_CC_RP = 2'h3
	} ccprd_cc_t;
	typedef struct packed {
		ccprd_cc_t cc1;
		ccprd_cc_t cc2;
		logic vbusPresent;
	} ccprd_sense_t;
	typedef struct packed {
		logic pullUp1;
		logic pullUp2;
		logic pullDown1;
		logic pullDown2;
		logic [1:0] pullUpSel;
		logic vbusOn;
		logic vconnOn1;
		logic vconnOn2;
		logic flipRoute;
		logic dataDfp;
		logic [1:0] loadLimit;
	} ccprd_drive_t;
	typedef enum logic [9:0] {
		CCPRD_ST_SRC_UNATT = 10'h001,
		CCPRD_ST_SRC_ATT = 10'h002,
		CCPRD_ST_SNK_UNATT = 10'h004,
		CCPRD_ST_SNK_ATT = 10'h008,
		CCPRD_ST_TRY_SRC = 10'h010,
		CCPRD_ST_TRY_SNK = 10'h020,
		CCPRD_ST_AUDIO = 10'h040,
		CCPRD_ST_DEBUG = 10'h080,
		CCPRD_ST_TRANS = 10'h100,
		CCPRD_ST_IDLE = 10'h200
	} ccprd_state_t;
endpackage
